// ===== logic/bufs_top.sv
// Top: bus and usage fault status flags with APB register access
`timescale 1ns/1ps
`default_nettype none

module bufs_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       clk_en,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [bufs_pkg::ADDR_W-1:0] paddr,
    input  wire logic [bufs_pkg::DATA_W-1:0] pwdata,
    output var  logic [bufs_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic                       ex_valid,
    input  wire logic [bufs_pkg::DATA_W-1:0] ex_pc,
    input  wire logic                       ex_divide,
    input  wire logic                       ex_divisor_zero,
    input  wire logic                       ex_mem_access,
    input  wire logic                       ex_unaligned,
    input  wire logic                       ex_multi_dword,
    input  wire logic                       ex_coproc,
    input  wire logic                       ex_ret_load,
    input  wire logic                       ex_ret_invalid,
    input  wire logic                       ex_state_illegal,
    input  wire logic                       ex_undecodable,
    input  wire logic                       fetch_error,
    input  wire logic                       fetch_flush,
    input  wire logic                       issue_valid,
    input  wire logic [bufs_pkg::DATA_W-1:0] issue_pc,
    input  wire logic                       dbus_error,
    input  wire logic                       dbus_precise,
    input  wire logic [bufs_pkg::DATA_W-1:0] dbus_addr,
    input  wire logic [bufs_pkg::DATA_W-1:0] dbus_pc,
    output var  logic                       usage_fault_pulse,
    output var  logic                       bus_fault_pulse,
    output var  logic [bufs_pkg::DATA_W-1:0] stacked_pc,
    output var  logic                       zero_divide_trap_enable,
    output var  logic                       misaligned_trap_enable
);

    // ****************************************
    // Address decode helper
    // ****************************************
    function automatic logic addr_hit(
        input logic [bufs_pkg::ADDR_W-1:0] a,
        input logic [bufs_pkg::ADDR_W-1:0] off
    );
        return a == off;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    bufs_pkg::bufs_apb_st_t           st_r;
    bufs_pkg::bufs_apb_st_t           st_nxt;
    logic                             pready_r;
    logic                             pslverr_r;
    logic [bufs_pkg::DATA_W-1:0]      prdata_r;
    logic [bufs_pkg::DATA_W-1:0]      prdata_nxt;
    logic [bufs_pkg::CTL_W-1:0]       ctl_r;
    logic [bufs_pkg::CTL_W-1:0]       ctl_nxt;
    logic [bufs_pkg::DATA_W-1:0]      faddr_r;
    logic [bufs_pkg::DATA_W-1:0]      faddr_nxt;
    logic [bufs_pkg::DATA_W-1:0]      retpc_r;
    logic [bufs_pkg::DATA_W-1:0]      retpc_nxt;
    logic                             fetch_pend_r;
    logic                             fetch_pend_nxt;
    logic                             uf_pulse_r;
    logic                             bf_pulse_r;
    logic [bufs_pkg::UF_W-1:0]        uf_q;
    logic [bufs_pkg::UF_W-1:0]        uf_set;
    logic [bufs_pkg::UF_W-1:0]        uf_clr;
    logic [bufs_pkg::BF_W-1:0]        bf_q;
    logic [bufs_pkg::BF_W-1:0]        bf_set;
    logic [bufs_pkg::BF_W-1:0]        bf_clr;

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic setup_ph;
    wire logic wr_done;
    wire logic hit_uf;
    wire logic hit_bf;
    wire logic hit_fa;
    wire logic hit_ctl;
    wire logic hit_pc;
    wire logic mapped;
    wire logic rd_take;

    assign setup_ph = psel & ~penable;
    // A write takes effect only on the completing access edge
    assign wr_done  = psel & penable & pwrite & pready_r;
    assign hit_uf   = addr_hit(paddr, bufs_pkg::OFF_UFLAGS);
    assign hit_bf   = addr_hit(paddr, bufs_pkg::OFF_BFLAGS);
    assign hit_fa   = addr_hit(paddr, bufs_pkg::OFF_FADDR);
    assign hit_ctl  = addr_hit(paddr, bufs_pkg::OFF_CTRL);
    assign hit_pc   = addr_hit(paddr, bufs_pkg::OFF_RETPC);
    assign mapped   = hit_uf | hit_bf | hit_fa | hit_ctl | hit_pc;
    assign rd_take  = setup_ph & ~pwrite;

    // ****************************************
    // Bus slave state machine
    // ****************************************
    // No wait states: answer follows setup
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            bufs_pkg::BUFS_IDLE: begin
                if (setup_ph) begin
                    st_nxt = bufs_pkg::BUFS_ANSWER;
                end
            end
            bufs_pkg::BUFS_ANSWER: begin
                st_nxt = bufs_pkg::BUFS_IDLE;
            end
            default: begin
                st_nxt = bufs_pkg::BUFS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= bufs_pkg::BUFS_IDLE;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            st_r      <= st_nxt;
            pready_r  <= (st_nxt == bufs_pkg::BUFS_ANSWER);
            pslverr_r <= (st_nxt == bufs_pkg::BUFS_ANSWER) & ~mapped;
        end
    end

    // ****************************************
    // Read data, sampled in the setup cycle
    // ****************************************
    wire logic [bufs_pkg::DATA_W-1:0] rd_uf;
    wire logic [bufs_pkg::DATA_W-1:0] rd_bf;
    wire logic [bufs_pkg::DATA_W-1:0] rd_ctl;

    // Upper bits of narrow registers read as zero
    assign rd_uf  = {{(bufs_pkg::DATA_W - bufs_pkg::UF_W){1'b0}}, uf_q};
    assign rd_bf  = {{(bufs_pkg::DATA_W - bufs_pkg::BF_W){1'b0}}, bf_q};
    assign rd_ctl = {{(bufs_pkg::DATA_W - bufs_pkg::CTL_W){1'b0}}, ctl_r};

    // Taken at setup; an access-cycle event shows next read
    assign prdata_nxt = hit_uf  ? rd_uf   :
                        hit_bf  ? rd_bf   :
                        hit_fa  ? faddr_r :
                        hit_ctl ? rd_ctl  :
                        hit_pc  ? retpc_r :
                                  bufs_pkg::WORD_RST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= bufs_pkg::WORD_RST;
        end else if (clk_en && rd_take) begin
            prdata_r <= prdata_nxt;
        end
    end

    // ****************************************
    // Trap control register
    // ****************************************
    assign ctl_nxt = (wr_done && hit_ctl) ?
                     pwdata[bufs_pkg::CTL_W-1:0] : ctl_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= bufs_pkg::CTL_RST;
        end else if (clk_en) begin
            ctl_r <= ctl_nxt;
        end
    end

    // ****************************************
    // Usage fault events
    // ****************************************
    wire logic ev_zdiv;
    wire logic ev_misal;
    wire logic ev_coproc;
    wire logic ev_retld;
    wire logic ev_state;
    wire logic ev_undef;
    wire logic ev_usage;

    assign ev_zdiv   = ex_valid & ex_divide & ex_divisor_zero
                     & ctl_r[bufs_pkg::CTL_ZDIV];
    // Multiple and doubleword forms ignore the trap enable
    assign ev_misal  = ex_valid & ex_mem_access & ex_unaligned
                     & (ctl_r[bufs_pkg::CTL_MISAL]
                     | ex_multi_dword);
    assign ev_coproc = ex_valid & ex_coproc;
    assign ev_retld  = ex_valid & ex_ret_load & ex_ret_invalid;
    // Undecodable wins over state-use so only one of the two is reported
    assign ev_state  = ex_valid & ex_state_illegal
                     & ~ex_undecodable;
    assign ev_undef  = ex_valid & ex_undecodable;
    assign ev_usage  = ev_zdiv | ev_misal | ev_coproc
                     | ev_retld | ev_state | ev_undef;

    assign uf_set = (bufs_pkg::UF_W'(ev_zdiv)   << bufs_pkg::UF_ZDIV)
                  | (bufs_pkg::UF_W'(ev_misal)  << bufs_pkg::UF_MISAL)
                  | (bufs_pkg::UF_W'(ev_coproc) << bufs_pkg::UF_COPROC)
                  | (bufs_pkg::UF_W'(ev_retld)  << bufs_pkg::UF_RETLD)
                  | (bufs_pkg::UF_W'(ev_state)  << bufs_pkg::UF_STATE)
                  | (bufs_pkg::UF_W'(ev_undef)  << bufs_pkg::UF_UNDEF);

    // Writing zero clears nothing
    assign uf_clr = (wr_done && hit_uf) ?
                    pwdata[bufs_pkg::UF_W-1:0] : '0;

    bufs_sticky #(
        .W    (bufs_pkg::UF_W),
        .MASK (bufs_pkg::UF_MASK),
        .RST  (bufs_pkg::UF_RST)
    ) u_uflags (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (clk_en),
        .set   (uf_set),
        .clr   (uf_clr),
        .q     (uf_q)
    );

    // ****************************************
    // Instruction fetch error tracking
    // ****************************************
    wire logic ev_ifetch;
    wire logic ev_exact;

    // Prefetch error only arms; the flag waits for the issue attempt
    assign ev_ifetch = issue_valid & fetch_pend_r;
    assign ev_exact  = dbus_error & dbus_precise;

    // A new error in the same cycle as a flush still arms
    // Pending survives idle cycles
    assign fetch_pend_nxt = fetch_error
                          | (fetch_pend_r & ~fetch_flush & ~issue_valid);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_pend_r <= 1'b0;
        end else if (clk_en) begin
            fetch_pend_r <= fetch_pend_nxt;
        end
    end

    // ****************************************
    // Bus fault flags
    // ****************************************
    assign bf_set = (bufs_pkg::BF_W'(ev_ifetch) << bufs_pkg::BF_IFETCH)
                  | (bufs_pkg::BF_W'(ev_exact)  << bufs_pkg::BF_EXACT)
                  | (bufs_pkg::BF_W'(ev_exact)  << bufs_pkg::BF_AVALID);

    assign bf_clr = (wr_done && hit_bf) ?
                    pwdata[bufs_pkg::BF_W-1:0] : '0;

    bufs_sticky #(
        .W    (bufs_pkg::BF_W),
        .MASK (bufs_pkg::BF_MASK),
        .RST  (bufs_pkg::BF_RST)
    ) u_bflags (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (clk_en),
        .set   (bf_set),
        .clr   (bf_clr),
        .q     (bf_q)
    );

    // ****************************************
    // Fault address capture
    // ****************************************
    // Hardware capture beats a software write in the same cycle;
    // a fetch error leaves the address untouched
    assign faddr_nxt = ev_exact               ? dbus_addr :
                       (wr_done && hit_fa)    ? pwdata    :
                                                faddr_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faddr_r <= bufs_pkg::WORD_RST;
        end else if (clk_en) begin
            faddr_r <= faddr_nxt;
        end
    end

    // ****************************************
    // Stacked return PC
    // ****************************************
    // Keeps only the newest fault PC
    // Precise data error first, then fetch error, then usage causes
    assign retpc_nxt = ev_exact  ? dbus_pc  :
                       ev_ifetch ? issue_pc :
                       ev_usage  ? ex_pc    :
                                   retpc_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retpc_r    <= bufs_pkg::WORD_RST;
            uf_pulse_r <= 1'b0;
            bf_pulse_r <= 1'b0;
        end else if (clk_en) begin
            retpc_r    <= retpc_nxt;
            uf_pulse_r <= ev_usage;
            bf_pulse_r <= ev_exact | ev_ifetch;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata                  = prdata_r;
    assign pready                  = pready_r;
    assign pslverr                 = pslverr_r;
    assign usage_fault_pulse       = uf_pulse_r;
    assign bus_fault_pulse         = bf_pulse_r;
    assign stacked_pc              = retpc_r;
    assign zero_divide_trap_enable = ctl_r[bufs_pkg::CTL_ZDIV];
    assign misaligned_trap_enable  = ctl_r[bufs_pkg::CTL_MISAL];

endmodule

`default_nettype wire

// ===== pkg/bufs_pkg.sv
// Package: register map, field positions and states of the fault status block
package bufs_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned UF_W   = 16;
    localparam int unsigned BF_W   = 8;
    localparam int unsigned CTL_W  = 2;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_UFLAGS = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_BFLAGS = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_FADDR  = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_RETPC  = 12'h010;

    // ****************************************
    // Usage fault cause bit positions
    // ****************************************
    localparam int unsigned UF_UNDEF  = 0;
    localparam int unsigned UF_STATE  = 1;
    localparam int unsigned UF_RETLD  = 2;
    localparam int unsigned UF_COPROC = 3;
    localparam int unsigned UF_MISAL  = 8;
    localparam int unsigned UF_ZDIV   = 9;

    // ****************************************
    // Bus fault cause bit positions
    // ****************************************
    localparam int unsigned BF_IFETCH = 0;
    localparam int unsigned BF_EXACT  = 1;
    localparam int unsigned BF_AVALID = 7;

    // ****************************************
    // Control bit positions
    // ****************************************
    localparam int unsigned CTL_ZDIV  = 0;
    localparam int unsigned CTL_MISAL = 1;

    // ****************************************
    // Implemented-bit masks and reset values
    // ****************************************
    localparam logic [UF_W-1:0]   UF_MASK  = 16'h030F;
    localparam logic [BF_W-1:0]   BF_MASK  = 8'h83;
    localparam logic [UF_W-1:0]   UF_RST   = 16'h0000;
    localparam logic [BF_W-1:0]   BF_RST   = 8'h00;
    localparam logic [CTL_W-1:0]  CTL_RST  = 2'h0;
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

    // ****************************************
    // Bus slave states
    // ****************************************
    typedef enum logic [0:0] {
        BUFS_IDLE,
        BUFS_ANSWER
    } bufs_apb_st_t;

endpackage

// ===== logic/bufs_sticky.sv
// Sticky write-one-to-clear flag field with per-bit implementation mask
`timescale 1ns/1ps
`default_nettype none

module bufs_sticky #(
    parameter int unsigned     W    = 16,
    parameter logic [W-1:0]    MASK = '1,
    parameter logic [W-1:0]    RST  = '0
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          en,
    input  wire logic [W-1:0]  set,
    input  wire logic [W-1:0]  clr,
    output var  logic [W-1:0]  q
);

    // ****************************************
    // One flop per implemented bit
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (MASK[i]) begin : g_impl
                logic q_r;
                logic q_nxt;
                // Set wins over a clear in the same cycle
                assign q_nxt = set[i] | (q_r & ~clr[i]);
                always_ff @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        q_r <= RST[i];
                    end else if (en) begin
                        q_r <= q_nxt;
                    end
                end
                assign q[i] = q_r;
            end else begin : g_rsvd
                assign q[i] = 1'b0;
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ===== bench/bufs_pipe_model.sv
// Pipeline model: emits one executed-instruction event per request
`timescale 1ns/1ps
`default_nettype none

module bufs_pipe_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic [9:0]  kind,
    input  wire logic [31:0] pc,
    output var  logic        ex_valid,
    output var  logic [31:0] ex_pc,
    output var  logic        ex_divide,
    output var  logic        ex_divisor_zero,
    output var  logic        ex_mem_access,
    output var  logic        ex_unaligned,
    output var  logic        ex_multi_dword,
    output var  logic        ex_coproc,
    output var  logic        ex_ret_load,
    output var  logic        ex_ret_invalid,
    output var  logic        ex_state_illegal,
    output var  logic        ex_undecodable
);
    // Idle PC toggles so a stale value is never mistaken for a fault PC
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ex_valid <= 1'b0;
            ex_pc <= 32'h0000_0000;
            {ex_divide, ex_divisor_zero, ex_mem_access, ex_unaligned,
             ex_multi_dword, ex_coproc, ex_ret_load, ex_ret_invalid,
             ex_state_illegal, ex_undecodable} <= 10'h000;
        end else begin
            ex_valid <= go;
            ex_pc <= go ? pc : ~ex_pc;
            // Undefined plus state-use both raised, as a real decoder may
            {ex_divide, ex_divisor_zero, ex_mem_access, ex_unaligned,
             ex_multi_dword, ex_coproc, ex_ret_load, ex_ret_invalid,
             ex_state_illegal, ex_undecodable} <= go ? kind : 10'h000;
        end
    end
endmodule

`default_nettype wire

// ===== bench/bufs_top_monitor.sv
// Checker: port-level timing of fault pulses, stacked PC and bus answers
`timescale 1ns/1ps
`default_nettype none

module bufs_top_monitor (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        clk_en,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic [bufs_pkg::ADDR_W-1:0] paddr,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        ex_valid,
    input wire logic [bufs_pkg::DATA_W-1:0] ex_pc,
    input wire logic                        ex_divide,
    input wire logic                        ex_divisor_zero,
    input wire logic                        ex_mem_access,
    input wire logic                        ex_unaligned,
    input wire logic                        ex_multi_dword,
    input wire logic                        ex_coproc,
    input wire logic                        ex_ret_load,
    input wire logic                        ex_ret_invalid,
    input wire logic                        ex_state_illegal,
    input wire logic                        ex_undecodable,
    input wire logic                        fetch_error,
    input wire logic                        fetch_flush,
    input wire logic                        issue_valid,
    input wire logic [bufs_pkg::DATA_W-1:0] issue_pc,
    input wire logic                        dbus_error,
    input wire logic                        dbus_precise,
    input wire logic [bufs_pkg::DATA_W-1:0] dbus_pc,
    input wire logic                        usage_fault_pulse,
    input wire logic                        bus_fault_pulse,
    input wire logic [bufs_pkg::DATA_W-1:0] stacked_pc,
    input wire logic                        zero_divide_trap_enable,
    input wire logic                        misaligned_trap_enable
);
    wire ucause = ex_coproc | (ex_ret_load & ex_ret_invalid)
        | ex_state_illegal | ex_undecodable
        | (ex_divide & ex_divisor_zero & zero_divide_trap_enable)
        | (ex_mem_access & ex_unaligned
           & (ex_multi_dword | misaligned_trap_enable));
    wire ev = clk_en & ex_valid;
    wire bus_ev = dbus_error | issue_valid;
    wire exact = clk_en & dbus_error & dbus_precise;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_usage_pc_stack: assert property (
        ev && ucause && !bus_ev |=>
        usage_fault_pulse && stacked_pc == $past(ex_pc))
        else $error("usage fault pulse or stacked pc wrong");
    a_usage_quiet: assert property (clk_en
        && !(ex_valid && ucause) |=> !usage_fault_pulse)
        else $error("usage pulse without cause");
    a_multi_always: assert property (ev && ex_mem_access && ex_unaligned
        && ex_multi_dword |=> usage_fault_pulse)
        else $error("unaligned multiple did not fault");
    a_bus_quiet: assert property (clk_en
        && !(dbus_error && dbus_precise)
        && !issue_valid |=> !bus_fault_pulse)
        else $error("bus pulse without issue or precise error");
    a_fetch_on_issue: assert property (clk_en && fetch_error
        && !fetch_flush
        ##1 clk_en && issue_valid && !fetch_flush && !dbus_error
        |=> bus_fault_pulse && stacked_pc == $past(issue_pc))
        else $error("fetch error not reported at issue");
    a_exact_pc: assert property (exact |=> bus_fault_pulse
        && stacked_pc == $past(dbus_pc)) else $error("precise error pc wrong");
    a_pc_hold: assert property (clk_en && !ex_valid && !bus_ev
        |=> $stable(stacked_pc)) else $error("stacked pc moved");
    a_apb_answer: assert property (clk_en && psel && !penable
        |=> pready ##1 !pready) else $error("apb answer timing wrong");
    a_unmapped_err: assert property (clk_en && psel && !penable
        && (paddr[1:0] != 2'h0 || paddr > bufs_pkg::OFF_RETPC) |=> pslverr)
        else $error("unmapped address not refused");
endmodule

bind bufs_top bufs_top_monitor u_monitor (.*);

`default_nettype wire

// ===== bench/bus_usage_fault_status_test.sv
// Testbench: fault status block over APB with the pipeline model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module bus_usage_fault_status_test;
    typedef struct packed {
        logic [1:0]  ctl;
        logic [9:0]  kind;
        logic [15:0] flags;
    } bufs_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, go = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [9:0]  kind = 10'h000;
    logic [31:0] pwdata = 32'h0, pc = 32'h0, prdata, rd, pc_q, ex_pc;
    logic        err, ex_valid, ex_divide, ex_divisor_zero, ex_mem_access;
    logic        ex_unaligned, ex_multi_dword, ex_coproc, ex_ret_load;
    logic        ex_ret_invalid, ex_state_illegal, ex_undecodable;
    logic        fetch_error = 1'b0, fetch_flush = 1'b0, issue_valid = 1'b0;
    logic        dbus_error = 1'b0, dbus_precise = 1'b0;
    logic [31:0] issue_pc = 32'h0000_2000, dbus_addr = 32'hA5A5_0004;
    logic [31:0] dbus_pc = 32'h0000_3000, stacked_pc;
    logic        usage_fault_pulse, bus_fault_pulse;
    logic        zero_divide_trap_enable, misaligned_trap_enable;
    int          failures = 0, n_compared = 0, cycles = 0;
    bufs_row_t   rows [12] = '{
        '{2'h1, 10'h300, 16'h0200}, '{2'h0, 10'h300, 16'h0000},
        '{2'h1, 10'h200, 16'h0000}, '{2'h2, 10'h0C0, 16'h0100},
        '{2'h0, 10'h0C0, 16'h0000}, '{2'h0, 10'h0E0, 16'h0100},
        '{2'h0, 10'h010, 16'h0008}, '{2'h0, 10'h00C, 16'h0004},
        '{2'h0, 10'h008, 16'h0000}, '{2'h0, 10'h002, 16'h0002},
        '{2'h0, 10'h003, 16'h0001}, '{2'h0, 10'h001, 16'h0001}};

    bufs_top dut (.*);
    bufs_pipe_model u_pipe (.*);

    always #12.5 pclk = ~pclk;

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 4000) begin
            failures++;
            test_done();
        end
    end

    task automatic test_done;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fire(input logic [9:0] k, input logic [31:0] p);
        @(posedge pclk);
        go <= 1'b1;
        kind <= k;
        pc <= p;
        @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic strobe(input logic [3:0] s);
        @(posedge pclk);
        {fetch_error, fetch_flush, issue_valid, dbus_error} <= s;
        @(posedge pclk);
        {fetch_error, fetch_flush, issue_valid, dbus_error} <= 4'h0;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 20; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            `CHK(rd, bufs_pkg::WORD_RST)
        end
        $display("reset values done");
        for (int i = 0; i < 12; i++) begin
            pc_q = 32'h0000_1000 + 32'(i * 4);
            apb(1'b1, bufs_pkg::OFF_CTRL, {30'h0, rows[i].ctl});
            fire(rows[i].kind, pc_q);
            `CHK({misaligned_trap_enable, zero_divide_trap_enable}, rows[i].ctl)
            apb(1'b0, bufs_pkg::OFF_UFLAGS, 32'h0);
            `CHK(rd, 32'(rows[i].flags))
            if (rows[i].flags != 16'h0000) begin
                apb(1'b0, bufs_pkg::OFF_RETPC, 32'h0);
                `CHK(rd, pc_q)
            end
            apb(1'b1, bufs_pkg::OFF_UFLAGS, 32'h0000_FFFF);
        end
        $display("cause table done");
        fire(10'h010, 32'h0000_1100);
        fire(10'h001, 32'h0000_1104);
        apb(1'b1, bufs_pkg::OFF_UFLAGS, 32'h0000_0000);
        apb(1'b0, bufs_pkg::OFF_UFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0009)
        apb(1'b1, bufs_pkg::OFF_UFLAGS, 32'hFFFF_FCF1);
        apb(1'b0, bufs_pkg::OFF_UFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0008)
        $display("sticky clear done");
        apb(1'b1, bufs_pkg::OFF_FADDR, 32'h1234_5678);
        strobe(4'h8);
        strobe(4'h4);
        strobe(4'h2);
        strobe(4'h8);
        apb(1'b0, bufs_pkg::OFF_BFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        strobe(4'h2);
        apb(1'b0, bufs_pkg::OFF_BFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0001)
        apb(1'b0, bufs_pkg::OFF_FADDR, 32'h0);
        `CHK(rd, 32'h1234_5678)
        apb(1'b0, bufs_pkg::OFF_RETPC, 32'h0);
        `CHK(rd, issue_pc)
        $display("fetch error done");
        apb(1'b1, bufs_pkg::OFF_BFLAGS, 32'h0000_00FF);
        strobe(4'h1);
        dbus_precise <= 1'b1;
        strobe(4'h1);
        apb(1'b0, bufs_pkg::OFF_BFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0082)
        apb(1'b0, bufs_pkg::OFF_FADDR, 32'h0);
        `CHK(rd, dbus_addr)
        apb(1'b0, bufs_pkg::OFF_RETPC, 32'h0);
        `CHK(rd, dbus_pc)
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        $display("precise error and unmapped done");
        apb(1'b1, bufs_pkg::OFF_BFLAGS, 32'h0000_00FF);
        fetch_error <= 1'b1;
        @(posedge pclk);
        {fetch_error, issue_valid} <= 2'b01;
        strobe(4'h0);
        apb(1'b0, bufs_pkg::OFF_BFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0001)
        $display("back to back fetch done");
        clk_en <= 1'b0;
        fire(10'h001, 32'h0000_1200);
        clk_en <= 1'b1;
        apb(1'b0, bufs_pkg::OFF_UFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0008)
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, bufs_pkg::OFF_UFLAGS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, bufs_pkg::OFF_RETPC, 32'hFFFF_FFFF);
        apb(1'b0, bufs_pkg::OFF_RETPC, 32'h0);
        `CHK(rd, 32'h0000_0000)
        $display("enable and reset done");
        test_done();
    end
endmodule

`default_nettype wire
